/* rtl/rcpps_pwm_divider.v */
// power-of-two pwm clock pre-divider with edges aligned to the system clock
`timescale 1ns/1ns
module rcpps_pwm_divider (
  input wire clk, // system clock
  input wire rst, // synchronous reset, active high
  input wire [2:0] code, // divisor code
  output reg tick_q // one-cycle pulse every 2^(code+1) cycles, every 64 cycles for codes above 5
);
  `include "rcpps_regs.vh"
  reg [5:0] cnt_q;
  reg [5:0] cnt_d;
  reg [5:0] mask;
  always @* begin
    // codes above 4 all saturate at /64
    case (code)
      3'h0: mask = 6'h01;
      3'h1: mask = 6'h03;
      3'h2: mask = 6'h07;
      3'h3: mask = 6'h0F;
      3'h4: mask = 6'h1F;
      default: mask = 6'h3F;
    endcase
    cnt_d = cnt_q + 6'h01;
  end
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // binary counter keeps ratios power-of-two and edges on system edges
      tick_q <= ((cnt_d & mask) == 6'h00);
    end
  end
endmodule // rcpps_pwm_divider

/* rtl/rcpps_regs.vh */
// register offsets, field positions, reset values and divider codes of the run clock block
`ifndef RCPPS_REGS_VH
`define RCPPS_REGS_VH
`define RCPPS_RUN_CLOCK_CONFIG_ADDR 12'h060
`define RCPPS_ALT_CLOCK_CONFIG_ADDR 12'h070
`define RCPPS_STATUS_ADDR 12'h074
`define RCPPS_ADDR_W 12
`define RCPPS_PWM_DIV_ENABLE_BIT 20
`define RCPPS_PWM_DIV_HI 19
`define RCPPS_PWM_DIV_LO 17
`define RCPPS_PLL_POWER_DOWN_BIT 13
`define RCPPS_RSVD_ONE_BIT 12
`define RCPPS_MAIN_SRC_BIT 11
`define RCPPS_SYSCLK_DIVISOR_HI 26
`define RCPPS_SYSCLK_DIVISOR_LO 23
`define RCPPS_ALT_OVERRIDE_BIT 31
`define RCPPS_ALT_SYSCLK_DIVISOR_HI 28
`define RCPPS_ALT_SYSCLK_DIVISOR_LO 23
`define RCPPS_PWM_DIV_RESET 3'h7
`define RCPPS_SYSCLK_DIVISOR_RESET 4'hF
`define RCPPS_ALT_SYSCLK_DIVISOR_RESET 6'h0F
`define RCPPS_PWM_DIV_ENABLE_RESET 1'b0
`define RCPPS_PLL_POWER_DOWN_RESET 1'b1
`define RCPPS_MAIN_SRC_RESET 1'b1
`define RCPPS_ALT_OVERRIDE_RESET 1'b0
`define RCPPS_PWM_DIV_MAX_CODE 3'h5
`define RCPPS_WRITABLE_MASK 32'h079E2800
`define RCPPS_ALT_WRITABLE_MASK 32'h9F800000
`endif

/* rtl/rcpps_top.v */
// run clock configuration middle field: pwm pre-divider, pll power-down and source select
`timescale 1ns/1ns
module rcpps_top (
  input wire SYS_CLK, // system clock, 125 MHz
  input wire RST, // synchronous reset, active high
  input wire PSEL, // apb select
  input wire PENABLE, // apb enable
  input wire PWRITE, // apb direction
  input wire [11:0] PADDR, // apb byte address
  input wire [31:0] PWDATA, // apb write data
  output reg [31:0] PRDATA, // apb read data
  output reg PREADY, // apb ready
  output reg PSLVERR, // apb error on unmapped address
  output reg PLL_POWER_DOWN, // to pll power-down input
  output reg MAIN_CLOCK_SOURCE, // 1: oscillator drives system, 0: divided pll
  output reg SYSCLK_DIVISOR_USE, // 1: system divider in the clock path
  output reg [5:0] SYSCLK_DIVISOR, // effective system divisor code
  output reg PWM_TICK // pwm timing reference pulse
);
  `include "rcpps_regs.vh"

  // writable field storage and next values
  reg pwm_div_enable_q;
  reg pwm_div_enable_d;
  reg [2:0] pwm_clock_divisor_q;
  reg [2:0] pwm_clock_divisor_d;
  reg pll_power_down_q;
  reg pll_power_down_d;
  reg main_clock_source_q;
  reg main_clock_source_d;
  reg [3:0] sysclk_divisor_q;
  reg [3:0] sysclk_divisor_d;
  reg alt_config_override_q;
  reg alt_config_override_d;
  reg [5:0] alt_sysclk_divisor_q;
  reg [5:0] alt_sysclk_divisor_d;

  // bus response next values
  reg pready_d;
  reg pslverr_d;
  reg [31:0] prdata_d;
  reg [31:0] rdata_d;
  reg hit_d;
  reg [31:0] cfg_word;
  reg [31:0] alt_word;
  reg [31:0] status_word;

  // control output next values
  reg pll_pd_out_d;
  reg main_src_out_d;
  reg sysclk_divisor_use_d;
  reg [5:0] eff_div_d;
  reg pwm_tick_d;

  wire div_tick;
  wire setup;
  wire acc_phase;
  wire wr_en;
  wire sel_cfg;
  wire sel_alt;
  wire sel_status;
  wire cfg_wr;
  wire alt_wr;
  wire [31:0] cfg_wdata;
  wire [31:0] alt_wdata;

  assign setup = PSEL & ~PENABLE;
  assign acc_phase = PSEL & PENABLE & PREADY;
  assign wr_en = acc_phase & PWRITE;
  // exact decode, so no word aliases anywhere else in the address space
  assign sel_cfg = (PADDR == `RCPPS_RUN_CLOCK_CONFIG_ADDR);
  assign sel_alt = (PADDR == `RCPPS_ALT_CLOCK_CONFIG_ADDR);
  assign sel_status = (PADDR == `RCPPS_STATUS_ADDR);
  assign cfg_wr = wr_en & sel_cfg;
  assign alt_wr = wr_en & sel_alt;
  // reserved bits are masked off here, so they never reach storage
  assign cfg_wdata = PWDATA & `RCPPS_WRITABLE_MASK;
  assign alt_wdata = PWDATA & `RCPPS_ALT_WRITABLE_MASK;

  rcpps_pwm_divider u_div (
    .clk(SYS_CLK),
    .rst(RST),
    .code(pwm_clock_divisor_q),
    .tick_q(div_tick)
  );

  // readback words; reserved bits read as constants
  always @* begin
    cfg_word = 32'h00000000;
    cfg_word[`RCPPS_SYSCLK_DIVISOR_HI:`RCPPS_SYSCLK_DIVISOR_LO] = sysclk_divisor_q;
    cfg_word[`RCPPS_PWM_DIV_ENABLE_BIT] = pwm_div_enable_q;
    cfg_word[`RCPPS_PWM_DIV_HI:`RCPPS_PWM_DIV_LO] = pwm_clock_divisor_q;
    cfg_word[`RCPPS_PLL_POWER_DOWN_BIT] = pll_power_down_q;
    cfg_word[`RCPPS_RSVD_ONE_BIT] = 1'b1;
    cfg_word[`RCPPS_MAIN_SRC_BIT] = main_clock_source_q;
    alt_word = 32'h00000000;
    alt_word[`RCPPS_ALT_OVERRIDE_BIT] = alt_config_override_q;
    alt_word[`RCPPS_ALT_SYSCLK_DIVISOR_HI:`RCPPS_ALT_SYSCLK_DIVISOR_LO] = alt_sysclk_divisor_q;
    status_word = {26'h0, SYSCLK_DIVISOR};
  end

  // read mux and address hit
  always @* begin
    hit_d = sel_cfg | sel_alt | sel_status;
    rdata_d = 32'h00000000;
    if (sel_cfg) begin
      rdata_d = cfg_word;
    end else if (sel_alt) begin
      rdata_d = alt_word;
    end else if (sel_status) begin
      rdata_d = status_word;
    end
  end

  // no wait state: ready answers in the cycle after setup, answer registered
  always @* begin
    pready_d = setup;
    prdata_d = PRDATA;
    pslverr_d = 1'b0;
    if (setup) begin
      // writes return zero on the read bus
      prdata_d = PWRITE ? 32'h00000000 : rdata_d;
      pslverr_d = ~hit_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= pready_d;
      PRDATA <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  // only a completed access with a hit reaches the fields; status is read only
  always @* begin
    pwm_div_enable_d = pwm_div_enable_q;
    pwm_clock_divisor_d = pwm_clock_divisor_q;
    pll_power_down_d = pll_power_down_q;
    main_clock_source_d = main_clock_source_q;
    sysclk_divisor_d = sysclk_divisor_q;
    alt_config_override_d = alt_config_override_q;
    alt_sysclk_divisor_d = alt_sysclk_divisor_q;
    if (cfg_wr) begin
      pwm_div_enable_d = cfg_wdata[`RCPPS_PWM_DIV_ENABLE_BIT];
      pwm_clock_divisor_d = cfg_wdata[`RCPPS_PWM_DIV_HI:`RCPPS_PWM_DIV_LO];
      pll_power_down_d = cfg_wdata[`RCPPS_PLL_POWER_DOWN_BIT];
      main_clock_source_d = cfg_wdata[`RCPPS_MAIN_SRC_BIT];
      sysclk_divisor_d = cfg_wdata[`RCPPS_SYSCLK_DIVISOR_HI:`RCPPS_SYSCLK_DIVISOR_LO];
    end
    if (alt_wr) begin
      alt_config_override_d = alt_wdata[`RCPPS_ALT_OVERRIDE_BIT];
      alt_sysclk_divisor_d = alt_wdata[`RCPPS_ALT_SYSCLK_DIVISOR_HI:`RCPPS_ALT_SYSCLK_DIVISOR_LO];
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      pwm_div_enable_q <= `RCPPS_PWM_DIV_ENABLE_RESET;
      pwm_clock_divisor_q <= `RCPPS_PWM_DIV_RESET;
      pll_power_down_q <= `RCPPS_PLL_POWER_DOWN_RESET;
      main_clock_source_q <= `RCPPS_MAIN_SRC_RESET;
      sysclk_divisor_q <= `RCPPS_SYSCLK_DIVISOR_RESET;
      alt_config_override_q <= `RCPPS_ALT_OVERRIDE_RESET;
      alt_sysclk_divisor_q <= `RCPPS_ALT_SYSCLK_DIVISOR_RESET;
    end else begin
      pwm_div_enable_q <= pwm_div_enable_d;
      pwm_clock_divisor_q <= pwm_clock_divisor_d;
      pll_power_down_q <= pll_power_down_d;
      main_clock_source_q <= main_clock_source_d;
      sysclk_divisor_q <= sysclk_divisor_d;
      alt_config_override_q <= alt_config_override_d;
      alt_sysclk_divisor_q <= alt_sysclk_divisor_d;
    end
  end

  // effective divisor and control outputs, each launched from a flip-flop
  always @* begin
    if (alt_config_override_q) begin
      eff_div_d = alt_sysclk_divisor_q;
    end else begin
      eff_div_d = {2'b00, sysclk_divisor_q};
    end
    pll_pd_out_d = pll_power_down_q;
    main_src_out_d = main_clock_source_q;
    // divider is forced in whenever the pll is the source
    sysclk_divisor_use_d = ~main_clock_source_q;
    // undivided reference is a tick on every system edge
    if (pwm_div_enable_q) begin
      pwm_tick_d = div_tick;
    end else begin
      pwm_tick_d = 1'b1;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      PLL_POWER_DOWN <= `RCPPS_PLL_POWER_DOWN_RESET;
      MAIN_CLOCK_SOURCE <= `RCPPS_MAIN_SRC_RESET;
      SYSCLK_DIVISOR_USE <= 1'b0;
      SYSCLK_DIVISOR <= {2'b00, `RCPPS_SYSCLK_DIVISOR_RESET};
      PWM_TICK <= 1'b0;
    end else begin
      PLL_POWER_DOWN <= pll_pd_out_d;
      MAIN_CLOCK_SOURCE <= main_src_out_d;
      SYSCLK_DIVISOR_USE <= sysclk_divisor_use_d;
      SYSCLK_DIVISOR <= eff_div_d;
      PWM_TICK <= pwm_tick_d;
    end
  end
endmodule // rcpps_top

/* sim/rcpps_bench.sv */
// self-checking bench for the run clock block
`timescale 1ns/1ns
module rcpps_bench;
  logic SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, PLL_POWER_DOWN, MAIN_CLOCK_SOURCE, SYSCLK_DIVISOR_USE, PWM_TICK;
  logic [5:0] SYSCLK_DIVISOR;
  int err_total = 0, tests_run = 0;
  rcpps_top dut (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PLL_POWER_DOWN(PLL_POWER_DOWN), .MAIN_CLOCK_SOURCE(MAIN_CLOCK_SOURCE),
    .SYSCLK_DIVISOR_USE(SYSCLK_DIVISOR_USE), .SYSCLK_DIVISOR(SYSCLK_DIVISOR), .PWM_TICK(PWM_TICK));
  always #4 SYS_CLK = ~SYS_CLK;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task t_reset;
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h078E3800);
    chk({PLL_POWER_DOWN, MAIN_CLOCK_SOURCE, SYSCLK_DIVISOR}, 32'hCF);
  endtask
  task t_fields;
    apb(1'b1, 12'h060, 32'hFFFFFFFF);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h079E3800);
    apb(1'b1, 12'h060, 32'h02800000);
    repeat (3) @(posedge SYS_CLK);
    chk({PLL_POWER_DOWN, MAIN_CLOCK_SOURCE, SYSCLK_DIVISOR_USE, SYSCLK_DIVISOR}, 32'h45);
    apb(1'b1, 12'h070, 32'h95000000);
    repeat (3) @(posedge SYS_CLK);
    chk(SYSCLK_DIVISOR, 32'h2A);
    apb(1'b0, 12'h070, 32'h0);
    chk(rd, 32'h95000000);
    apb(1'b0, 12'h074, 32'h0);
    chk(rd, 32'h0000002A);
    apb(1'b1, 12'h070, 32'h0);
    repeat (3) @(posedge SYS_CLK);
    chk(SYSCLK_DIVISOR, 32'h05);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task t_pwm;
    int n;
    logic [31:0] w;
    // the window is a multiple of every period, so a free-running divider gives exact counts
    for (int c = 0; c < 9; c++) begin
      // read-modify-write: every bit outside the pwm fields goes back as it reads
      apb(1'b0, 12'h060, 32'h0);
      w = c < 8 ? (rd & 32'hFFE1FFFF) | 32'h00100000 | (c << 17) : rd & 32'hFFEFFFFF;
      apb(1'b1, 12'h060, w);
      repeat (4) @(posedge SYS_CLK);
      n = 0;
      repeat (128) begin
        @(posedge SYS_CLK);
        if (PWM_TICK === 1'b1) n++;
      end
      chk(n, c < 8 ? 128 >> ((c > 5 ? 5 : c) + 1) : 128);
    end
  endtask
  task t_rerst;
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    apb(1'b0, 12'h070, 32'h0);
    chk(rd, 32'h07800000);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h078E3800);
    chk({PLL_POWER_DOWN, MAIN_CLOCK_SOURCE, SYSCLK_DIVISOR_USE, PWM_TICK, SYSCLK_DIVISOR}, 32'h34F);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_reset;
    t_fields;
    t_pwm;
    t_rerst;
    summarize;
  end
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule // rcpps_bench

/* sim/rcpps_props.sv */
// port assertions for the run clock block
`timescale 1ns/1ns
module rcpps_props (
  input wire SYS_CLK, // clock
  input wire RST, // reset
  input wire PSEL, // select
  input wire PENABLE, // enable
  input wire PWRITE, // direction
  input wire [11:0] PADDR, // address
  input wire [31:0] PWDATA, // write data
  input wire [31:0] PRDATA, // read data
  input wire PREADY, // ready
  input wire PSLVERR, // error
  input wire PLL_POWER_DOWN, // pll off
  input wire MAIN_CLOCK_SOURCE, // source
  input wire SYSCLK_DIVISOR_USE, // divider used
  input wire [5:0] SYSCLK_DIVISOR, // divisor
  input wire PWM_TICK // pwm tick
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence acc_s; PSEL && PENABLE && PREADY; endsequence
  sequence cfg_wr_s; acc_s ##0 (PWRITE && PADDR == 12'h060); endsequence
  sequence alt_wr_s; acc_s ##0 (PWRITE && PWDATA[31] && PADDR == 12'h070); endsequence
  rdy_pulse_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after setup");
  pll_pd_a: assert property (cfg_wr_s |-> ##2 PLL_POWER_DOWN == $past(PWDATA[13], 2))
    else $error("pll power-down not from bit 13");
  src_sel_a: assert property (cfg_wr_s |-> ##2 MAIN_CLOCK_SOURCE == $past(PWDATA[11], 2))
    else $error("source select not from bit 11");
  div_use_a: assert property (SYSCLK_DIVISOR_USE != MAIN_CLOCK_SOURCE)
    else $error("divider not forced with pll");
  alt_div_a: assert property (alt_wr_s |-> ##2 SYSCLK_DIVISOR == $past(PWDATA[28:23], 2))
    else $error("override divisor not taken");
  rsvd_read_a: assert property (acc_s ##0 (!PWRITE && PADDR == 12'h060) |->
    (PRDATA & 32'h0021D400) == 32'h00001000)
    else $error("reserved bits read wrong");
  tick_full_a: assert property (cfg_wr_s ##0 !PWDATA[20] |-> ##2 PWM_TICK [*2])
    else $error("undivided pwm reference missing");
  tick_div_a: assert property (cfg_wr_s ##0 PWDATA[20] |->
    ##4 !(PWM_TICK && $past(PWM_TICK)) [*4])
    else $error("divided pwm tick too long");
  err_map_a: assert property (acc_s ##0 (PADDR == 12'h100) |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
endmodule // rcpps_props
bind rcpps_top rcpps_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PLL_POWER_DOWN(PLL_POWER_DOWN),
  .MAIN_CLOCK_SOURCE(MAIN_CLOCK_SOURCE), .SYSCLK_DIVISOR_USE(SYSCLK_DIVISOR_USE),
  .SYSCLK_DIVISOR(SYSCLK_DIVISOR), .PWM_TICK(PWM_TICK));
